// ### rtl/flmc_pkg.sv
// shared constants and types of the flash led mode control block
package flmc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TMR_BASE_MS = 100;
  localparam int TMR_STEP_MS = 50;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h30;
  localparam logic [7:0] SUB_ID = 8'h00;
  localparam logic [7:0] SUB_VER = 8'h01;
  localparam logic [7:0] SUB_TMR = 8'h02;
  localparam logic [7:0] SUB_CUR = 8'h03;
  localparam logic [7:0] SUB_OMODE = 8'h04;
  localparam logic [7:0] SUB_FAULT = 8'h05;
  localparam logic [7:0] SUB_INCTL = 8'h06;
  localparam logic [7:0] RST_TMR = 8'h0f;
  localparam logic [7:0] RST_CUR = 8'h61;
  localparam logic [7:0] RST_OMODE = 8'hb4;
  localparam logic [7:0] RST_FAULT = 8'h08;
  localparam logic [7:0] RST_INCTL = 8'h06;
  localparam int OM_LVL = 5;
  localparam int OM_TORCH = 4;
  localparam int OM_LEDON = 3;
  localparam int OM_STB = 2;
  localparam logic [1:0] OM_ASSIST = 2'h2;
  localparam logic [1:0] OM_FLASH = 2'h3;
  localparam int IC_POL = 2;
  localparam int IC_TXM = 1;
  localparam int FT_OVP = 7;
  localparam int FT_TMO = 4;
  localparam int FT_TWO = 3;
  localparam logic [7:0] FT_WMASK = 8'h08;
  localparam logic [8:0] MA_STEP = 9'h014;
  localparam logic [8:0] MA_LOW_BASE = 9'h014;
  localparam logic [8:0] MA_HIGH_BASE = 9'h0c8;
  localparam logic [8:0] MA_BIT_LOW_ONE = 9'h050;
  localparam logic [8:0] MA_BIT_LOW_TWO = 9'h028;
  localparam logic [8:0] MA_BIT_HIGH_ONE = 9'h1f4;
  localparam logic [8:0] MA_BIT_HIGH_TWO = 9'h140;

  typedef enum logic [1:0] {M_OFF, M_TORCH, M_ASSIST, M_FLASH} flmc_mode_t;

  typedef struct packed {
    logic uv_lock;
    logic if_sel;
    logic bit_one;
    logic bit_two;
    logic torch;
    logic strobe;
    logic tx_mask;
    logic ovp;
    logic two_led;
  } flmc_pins_t;
endpackage

// ### rtl/flmc_i2c_slave.sv
// i2c byte engine with auto-incrementing subaddress
`timescale 1ns/1ps
module flmc_i2c_slave
  import flmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic act_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] rdata_i,
  output logic sda_oe_o,
  output logic wr_o,
  output logic ld_o,
  output logic [7:0] sub_o,
  output logic [7:0] wdata_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_SUB, S_SACK, S_WDAT, S_WACK, S_RDAT, S_RACK
  } flmc_i2c_st_t;

  flmc_i2c_st_t st_r;
  logic scl_q_r;
  logic sda_q_r;
  logic rd_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;

  wire scl_rise = scl_i & ~scl_q_r;
  wire scl_fall = ~scl_i & scl_q_r;
  wire start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire stop = scl_i & scl_q_r & ~sda_q_r & sda_i;
  wire rx_st = (st_r == S_ADDR) | (st_r == S_SUB) | (st_r == S_WDAT);
  wire byte_end = (cnt_r == 4'h8);
  wire addr_hit = (sh_r[7:1] == I2C_DEV_ADDR);
  // a read byte is fetched at the falling edge that opens it
  wire load_rd = ((st_r == S_AACK) & rd_r) | (st_r == S_RACK);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= S_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      rd_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      sda_oe_o <= 1'b0;
      wr_o <= 1'b0;
      ld_o <= 1'b0;
      sub_o <= 8'h00;
      wdata_o <= 8'h00;
    end else if (ce_i) begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      wr_o <= 1'b0;
      ld_o <= 1'b0;
      if (!act_i || stop) begin
        st_r <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start) begin
        st_r <= S_ADDR;
        cnt_r <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (rx_st && scl_rise) begin
        sh_r <= {sh_r[6:0], sda_i};
        cnt_r <= cnt_r + 4'h1;
      end else if (st_r == S_RACK && scl_rise && sda_i) begin
        st_r <= S_IDLE;
      end else if (scl_fall && load_rd) begin
        sh_r <= rdata_i;
        sda_oe_o <= ~rdata_i[7];
        ld_o <= 1'b1;
        sub_o <= sub_o + 8'h01;
        cnt_r <= 4'h0;
        st_r <= S_RDAT;
      end else if (scl_fall) begin
        case (st_r)
          S_ADDR: begin
            if (byte_end) begin
              sda_oe_o <= addr_hit;
              rd_r <= sh_r[0];
              st_r <= addr_hit ? S_AACK : S_IDLE;
            end
          end
          S_SUB: begin
            if (byte_end) begin
              sub_o <= sh_r;
              sda_oe_o <= 1'b1;
              st_r <= S_SACK;
            end
          end
          S_WDAT: begin
            if (byte_end) begin
              wdata_o <= sh_r;
              wr_o <= 1'b1;
              sda_oe_o <= 1'b1;
              st_r <= S_WACK;
            end
          end
          S_AACK: begin
            sda_oe_o <= 1'b0;
            cnt_r <= 4'h0;
            st_r <= S_SUB;
          end
          S_SACK: begin
            sda_oe_o <= 1'b0;
            cnt_r <= 4'h0;
            st_r <= S_WDAT;
          end
          S_WACK: begin
            sda_oe_o <= 1'b0;
            cnt_r <= 4'h0;
            sub_o <= sub_o + 8'h01;
            st_r <= S_WDAT;
          end
          S_RDAT: begin
            if (cnt_r == 4'h7) begin
              sda_oe_o <= 1'b0;
              st_r <= S_RACK;
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              sda_oe_o <= ~sh_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
          default: st_r <= st_r;
        endcase
      end
    end
  end
endmodule

// ### rtl/flmc_top.sv
// flash led mode control: pin sync, mode decode, registers, flash timer, faults
// Notes on behaviour
// - select pin picks i2c or two-bit control
// - overvoltage turns led off, records fault
// - assist may go straight to flash
// - torch and assist share one current
// - bits decode off, assist, reserved, flash
// - bits low: torch request picks torch
// - two-bit low current 80 or 40
// - two-bit flash current 500 or 320
// - transmit limit drops flash to assist current
// - i2c address 0x60 write, 0x61 read
// - i2c torch needs enable bit; 20-160 mA
// - i2c flash current from register, 200-500
// - undervoltage returns all registers to defaults
// - subaddress byte first, each byte acknowledged
// - writes auto-increment subaddress until stop
// - reads auto-increment subaddress until the host's nack or a stop
// - level strobe flash timeout raises fault
// - bit 0 least, bit 7 most significant
// - read-only design id at 0x00
// - fault shuts down; reading 0x05 clears
// - two-bit mode: both mode bits and torch request low clears fault
// - mode field standby, reserved, assist, flash
`timescale 1ns/1ps
module flmc_top
  import flmc_pkg::*;
#(
  parameter logic [7:0] DESIGN_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] VERSION_ID = 8'h01, // arbitrary value
  parameter int TMR_BASE_CYC = TMR_BASE_MS * (CLK_HZ / 1000),
  parameter int TMR_STEP_CYC = TMR_STEP_MS * (CLK_HZ / 1000)
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic undervoltage_lockout_i,
  input wire logic interface_select_i,
  input wire logic mode_bit_one_i,
  input wire logic mode_bit_two_i,
  output logic mode_bit_two_o,
  output logic mode_bit_two_oe_o,
  input wire logic continuous_light_request_i,
  input wire logic flash_trigger_i,
  output logic flash_trigger_o,
  output logic flash_trigger_oe_o,
  input wire logic transmit_burst_limit_i,
  input wire logic boost_output_sense_ovp_i,
  input wire logic two_led_detect_i,
  output flmc_mode_t led_mode_o,
  output logic [8:0] led_current_ma_o
);
  flmc_pins_t pin_raw;
  flmc_pins_t pin_meta_r;
  flmc_pins_t pin_r;
  logic [7:0] tmr_r;
  logic [7:0] cur_r;
  logic [7:0] omode_r;
  logic [7:0] fault_r;
  logic [7:0] inctl_r;
  logic stb_prev_r;
  logic edge_lat_r;
  logic tmo_r;
  logic [25:0] tcnt_r;
  flmc_mode_t mode_r;
  flmc_mode_t mode_nxt;
  logic [8:0] cur_ma_r;
  logic [8:0] cur_nxt;
  logic stb_o_r;
  logic stb_oe_r;
  logic sl_wr;
  logic sl_ld;
  logic [7:0] sl_sub;
  logic [7:0] sl_wdata;
  logic [7:0] rdata;

  assign pin_raw = {undervoltage_lockout_i, interface_select_i, mode_bit_one_i,
    mode_bit_two_i, continuous_light_request_i, flash_trigger_i,
    transmit_burst_limit_i, boost_output_sense_ovp_i, two_led_detect_i};

  // every pin is asynchronous to clk_i; nothing reads pin_meta_r but pin_r
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta_r <= '0;
      pin_r <= '0;
    end else if (clk_en_i) begin
      pin_meta_r <= pin_raw;
      pin_r <= pin_meta_r;
    end
  end

  // undervoltage acts as a synchronous reset of all control state
  wire rst_all = sys_rst_i | pin_r.uv_lock;
  wire i2c_mode = pin_r.if_sel;

  flmc_i2c_slave u_i2c (
    .clk_i(clk_i),
    .rst_i(rst_all),
    .ce_i(clk_en_i),
    .act_i(i2c_mode),
    .scl_i(pin_r.bit_one),
    .sda_i(pin_r.bit_two),
    .rdata_i(rdata),
    .sda_oe_o(mode_bit_two_oe_o),
    .wr_o(sl_wr),
    .ld_o(sl_ld),
    .sub_o(sl_sub),
    .wdata_o(sl_wdata)
  );
  assign mode_bit_two_o = 1'b0;

  // register write decode; id, version and unmapped addresses take no write
  wire wr_tmr = sl_wr & (sl_sub == SUB_TMR);
  wire wr_cur = sl_wr & (sl_sub == SUB_CUR);
  wire wr_omode = sl_wr & (sl_sub == SUB_OMODE);
  wire wr_fault = sl_wr & (sl_sub == SUB_FAULT);
  wire wr_inctl = sl_wr & (sl_sub == SUB_INCTL);
  // the engine has already stepped the subaddress when it signals a load
  wire [7:0] ld_sub = sl_sub - 8'h01;
  wire fault_rd = sl_ld & (ld_sub == SUB_FAULT);

  always_comb begin
    case (sl_sub)
      SUB_ID: rdata = DESIGN_ID;
      SUB_VER: rdata = VERSION_ID;
      SUB_TMR: rdata = tmr_r;
      SUB_CUR: rdata = {cur_r[7:4], 1'b0, cur_r[2:0]};
      SUB_OMODE: rdata = omode_r;
      SUB_FAULT: rdata = {fault_r[FT_OVP], 2'b00, fault_r[FT_TMO], fault_r[FT_TWO], 3'b000};
      SUB_INCTL: rdata = {5'b00000, inctl_r[2:1], 1'b0};
      default: rdata = 8'h00;
    endcase
  end

  // all fields use bit 0 as lsb, as written on the wire msb first
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      tmr_r <= RST_TMR;
      cur_r <= RST_CUR;
      omode_r <= RST_OMODE;
      inctl_r <= RST_INCTL;
    end else if (clk_en_i) begin
      if (wr_tmr) tmr_r <= sl_wdata;
      if (wr_cur) cur_r <= sl_wdata;
      if (wr_omode) omode_r <= sl_wdata;
      if (wr_inctl) inctl_r <= sl_wdata;
    end
  end

  // strobe sensing: polarity bit chooses which level or edge is active
  wire stb_act = (pin_r.strobe == inctl_r[IC_POL]);
  wire stb_edge = stb_act & ~stb_prev_r;
  wire stb_en = omode_r[OM_STB];
  wire lvl_mode = omode_r[OM_LVL];
  wire lvl_flash = i2c_mode & stb_en & lvl_mode & stb_act;
  wire led_on = omode_r[OM_LEDON];
  wire sw_flash = led_on & (omode_r[1:0] == OM_FLASH);
  wire sw_assist = led_on & (omode_r[1:0] == OM_ASSIST);
  wire flash_req = sw_flash | lvl_flash | edge_lat_r;

  wire [25:0] tmr_limit = 26'(TMR_BASE_CYC + TMR_STEP_CYC * int'(tmr_r[3:0]));
  wire tmo_hit = i2c_mode & (mode_r == M_FLASH) & (tcnt_r == tmr_limit);
  wire tmo_fault = tmo_hit & lvl_flash;
  wire fault_any = fault_r[FT_OVP] | fault_r[FT_TMO];
  wire bits_idle = ~pin_r.bit_one & ~pin_r.bit_two & ~pin_r.torch;
  wire fault_clr = i2c_mode ? fault_rd : bits_idle;

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      fault_r <= RST_FAULT;
    end else if (clk_en_i) begin
      fault_r[FT_OVP] <= pin_r.ovp | (fault_r[FT_OVP] & ~fault_clr);
      fault_r[FT_TMO] <= tmo_fault | (fault_r[FT_TMO] & ~fault_clr);
      if (wr_fault) fault_r[FT_TWO] <= sl_wdata[FT_TWO];
    end
  end

  // flash timer; edge flash ends on expiry, level flash faults
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      stb_prev_r <= 1'b0;
      edge_lat_r <= 1'b0;
      tmo_r <= 1'b0;
      tcnt_r <= '0;
    end else if (clk_en_i) begin
      stb_prev_r <= stb_act;
      if (!i2c_mode || tmo_hit || fault_any) edge_lat_r <= 1'b0;
      else if (stb_en && !lvl_mode && stb_edge) edge_lat_r <= 1'b1;
      if (tmo_hit) tmo_r <= 1'b1;
      else if (!flash_req) tmo_r <= 1'b0;
      if (mode_r != M_FLASH) tcnt_r <= '0;
      else if (!tmo_hit) tcnt_r <= tcnt_r + 26'h1;
    end
  end

  // mode selection
  wire [1:0] bits = {pin_r.bit_one, pin_r.bit_two};
  always_comb begin
    mode_nxt = M_OFF;
    if (fault_any) begin
      mode_nxt = M_OFF;
    end else if (i2c_mode) begin
      if (flash_req && !tmo_r && !tmo_hit) mode_nxt = M_FLASH;
      else if (sw_assist) mode_nxt = M_ASSIST;
      else if (pin_r.torch && omode_r[OM_TORCH]) mode_nxt = M_TORCH;
    end else begin
      case (bits)
        2'b01: mode_nxt = M_ASSIST;
        2'b11: mode_nxt = M_FLASH;
        2'b00: mode_nxt = pin_r.torch ? M_TORCH : M_OFF;
        default: mode_nxt = M_OFF;
      endcase
    end
  end

  // current selection; torch and assist share the low setting
  wire two_bits = pin_r.two_led;
  wire [8:0] low_i2c = MA_LOW_BASE + MA_STEP * {6'h00, cur_r[2:0]};
  wire [8:0] high_i2c = MA_HIGH_BASE + MA_STEP * {5'h00, cur_r[7:4]};
  wire [8:0] low_bits = two_bits ? MA_BIT_LOW_TWO : MA_BIT_LOW_ONE;
  wire [8:0] high_bits = two_bits ? MA_BIT_HIGH_TWO : MA_BIT_HIGH_ONE;
  wire [8:0] low_ma = i2c_mode ? low_i2c : low_bits;
  wire [8:0] high_ma = i2c_mode ? high_i2c : high_bits;
  wire tx_cut = pin_r.tx_mask & (~i2c_mode | inctl_r[IC_TXM]);

  always_comb begin
    case (mode_nxt)
      M_FLASH: cur_nxt = tx_cut ? low_ma : high_ma;
      M_TORCH: cur_nxt = low_ma;
      M_ASSIST: cur_nxt = low_ma;
      default: cur_nxt = 9'h000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      mode_r <= M_OFF;
      cur_ma_r <= 9'h000;
      stb_o_r <= 1'b0;
      stb_oe_r <= 1'b0;
    end else if (clk_en_i) begin
      mode_r <= mode_nxt;
      cur_ma_r <= cur_nxt;
      stb_o_r <= pin_r.two_led;
      stb_oe_r <= ~i2c_mode;
    end
  end

  // in two-bit mode the trigger pin reports the led count instead
  assign flash_trigger_o = stb_o_r;
  assign flash_trigger_oe_o = stb_oe_r;
  assign led_mode_o = mode_r;
  assign led_current_ma_o = cur_ma_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_all || !clk_en_i);

  a_ovp_shuts_off: assert property (
    pin_r.ovp |=> fault_r[FT_OVP] ##1 (mode_r == M_OFF))
    else $error("overvoltage did not shut the led off");
  a_bits_flash: assert property (
    !i2c_mode && pin_r.bit_one && pin_r.bit_two && !fault_any |=> mode_r == M_FLASH)
    else $error("both mode bits high did not give flash");
  a_bits_torch: assert property (
    !i2c_mode && bits == 2'b00 && pin_r.torch && !fault_any |=> mode_r == M_TORCH)
    else $error("torch request not honoured in two-bit mode");
  a_bits_reserved: assert property (
    !i2c_mode && bits == 2'b10 |=> led_current_ma_o == 9'h000)
    else $error("reserved code drove current");
  a_mask_current: assert property (
    !i2c_mode && bits == 2'b11 && pin_r.tx_mask && !fault_any
    |=> led_current_ma_o == ($past(pin_r.two_led) ? MA_BIT_LOW_TWO : MA_BIT_LOW_ONE))
    else $error("transmit limit did not cut flash current");
  a_flash_current: assert property (
    !i2c_mode && bits == 2'b11 && !pin_r.tx_mask && !fault_any
    |=> led_current_ma_o == ($past(pin_r.two_led) ? MA_BIT_HIGH_TWO : MA_BIT_HIGH_ONE))
    else $error("two-bit flash current wrong");
  a_torch_gate: assert property (
    i2c_mode && !omode_r[OM_TORCH] && !sw_assist && !flash_req |=> mode_r == M_OFF)
    else $error("torch ran while not allowed");
  a_tmo_fault: assert property (
    tmo_fault |=> fault_r[FT_TMO] ##1 (mode_r == M_OFF))
    else $error("level flash timeout did not fault");
  a_read_clear: assert property (
    i2c_mode && fault_rd && !pin_r.ovp && !tmo_fault |=> !fault_any)
    else $error("fault read did not clear flags");
  a_bits_clear: assert property (
    !i2c_mode && bits_idle && !pin_r.ovp |=> !fault_any)
    else $error("two-bit idle did not clear fault");
  a_id_read: assert property (
    sl_sub == SUB_ID |-> rdata == DESIGN_ID)
    else $error("design id read wrong");
  a_unmapped_zero: assert property (
    sl_sub > SUB_INCTL |-> rdata == 8'h00)
    else $error("unmapped read not zero");

  c_bits_flash: cover property (!i2c_mode && mode_r == M_ASSIST ##1 mode_r == M_FLASH);
  c_i2c_write: cover property (wr_omode);
  c_tmo_fault: cover property (tmo_fault);
  c_tx_cut: cover property (mode_r == M_FLASH && tx_cut);
endmodule

// ### test/flmc_host.sv
// host processor model: i2c master on the two control pins, or two-bit pin driver
`timescale 1ns/1ps
module flmc_host (
  input wire logic clk_i,
  input wire logic i2c_i,
  input wire logic sel_one_i,
  input wire logic sel_two_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic scl_r = 1'b1;
  logic low_r = 1'b0;
  // sda has a pull-up: a released line reads high, never the last value
  assign scl_o = i2c_i ? scl_r : sel_one_i;
  assign sda_o = i2c_i ? ~(low_r | sda_oe_i) : sel_two_i;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // also serves as repeated start; scl stands high between frames
  task automatic start();
    tick(2);
    low_r <= 1'b0;
    tick(2);
    scl_r <= 1'b1;
    tick(4);
    low_r <= 1'b1;
    tick(4);
    scl_r <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    low_r <= 1'b1;
    tick(2);
    scl_r <= 1'b1;
    tick(4);
    low_r <= 1'b0;
    tick(4);
  endtask
  // sda moves mid low phase so the device's synchronisers never see it race scl
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    low_r <= ~b;
    tick(2);
    scl_r <= 1'b1;
    tick(3);
    #1 r = sda_o;
    tick(1);
    scl_r <= 1'b0;
  endtask
  // msb first; ack_in high releases sda during the ninth bit
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ack_in, ack);
  endtask
endmodule

// ### test/flmc_top_test.sv
// self-checking bench of the flash led mode control block
`timescale 1ns/1ps
module flmc_top_test
  import flmc_pkg::*;
;
  localparam logic [7:0] DID = 8'h3c; // arbitrary value
  logic clk_i = 1'b0;
  logic rst = 1'b1;
  logic low_supply = 1'b0;
  logic ce = 1'b1;
  logic isel = 1'b1;
  logic sel_one = 1'b0;
  logic sel_two = 1'b0;
  logic sda_do;
  logic torch = 1'b0;
  logic strobe = 1'b0;
  logic tx = 1'b0;
  logic ovp = 1'b0;
  logic two_led = 1'b0;
  logic scl;
  logic sda;
  logic sda_oe;
  logic ft_o;
  logic ft_oe;
  logic ft_pin;
  flmc_mode_t led_mode_o;
  logic [8:0] led_current_ma_o;
  int n_fail = 0;
  int num_checks = 0;
  // strobe pin turns around: the device drives it in two-bit mode
  assign ft_pin = ft_oe ? ft_o : strobe;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // short flash timer keeps the run brief: limit is 50 + 10 * setting cycles
  flmc_top #(.DESIGN_ID(DID), .TMR_BASE_CYC(50), .TMR_STEP_CYC(10)) i_dut (
    .clk_i(clk_i), .sys_rst_i(rst), .clk_en_i(ce), .undervoltage_lockout_i(low_supply),
    .interface_select_i(isel), .mode_bit_one_i(scl), .mode_bit_two_i(sda),
    .mode_bit_two_o(sda_do), .mode_bit_two_oe_o(sda_oe), .continuous_light_request_i(torch),
    .flash_trigger_i(ft_pin), .flash_trigger_o(ft_o), .flash_trigger_oe_o(ft_oe),
    .transmit_burst_limit_i(tx), .boost_output_sense_ovp_i(ovp),
    .two_led_detect_i(two_led), .led_mode_o(led_mode_o),
    .led_current_ma_o(led_current_ma_o));
  flmc_host i_host (.clk_i(clk_i), .i2c_i(isel), .sel_one_i(sel_one), .sel_two_i(sel_two),
    .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] d[$]);
    logic [7:0] q;
    logic a;
    i_host.start();
    i_host.xfer(8'h60, 1'b1, q, a);
    chk("write address ack", a, 9'h000);
    i_host.xfer(s, 1'b1, q, a);
    foreach (d[i]) begin
      i_host.xfer(d[i], 1'b1, q, a);
      chk("data ack", a, 9'h000);
    end
    i_host.stop();
    i_host.tick(4);
  endtask
  task automatic rd(input logic [7:0] s, input logic [7:0] e[$]);
    logic [7:0] q;
    logic a;
    i_host.start();
    i_host.xfer(8'h60, 1'b1, q, a);
    i_host.xfer(s, 1'b1, q, a);
    i_host.start();
    i_host.xfer(8'h61, 1'b1, q, a);
    chk("read address ack", a, 9'h000);
    foreach (e[i]) begin
      i_host.xfer(8'hff, i == e.size() - 1, q, a);
      chk("read byte", q, e[i]);
    end
    i_host.stop();
  endtask
  task automatic pins(input logic [3:0] p, input flmc_mode_t m, input logic [8:0] c);
    {sel_one, sel_two, torch, tx} <= p;
    i_host.tick(6);
    #1;
    chk("mode", led_mode_o, m);
    chk("current", led_current_ma_o, c);
  endtask
  task automatic t_regs();
    rd(SUB_ID, '{DID, 8'h01, RST_TMR, RST_CUR, RST_OMODE, RST_FAULT, RST_INCTL, 8'h00});
    chk("sda pull level", sda_do, 9'h000);
    $display("register defaults done");
  endtask
  task automatic t_write();
    logic [7:0] q;
    logic a;
    wr(SUB_CUR, '{8'h35, 8'h1b});
    #1;
    chk("software flash", led_mode_o, M_FLASH);
    chk("flash current", led_current_ma_o, 9'h104);
    tx <= 1'b1;
    i_host.tick(6);
    #1;
    chk("masked flash", led_current_ma_o, 9'h078);
    tx <= 1'b0;
    wr(SUB_OMODE, '{8'h1a});
    #1;
    chk("assist", led_mode_o, M_ASSIST);
    chk("assist current", led_current_ma_o, 9'h078);
    wr(SUB_OMODE, '{8'h10});
    torch <= 1'b1;
    i_host.tick(6);
    #1;
    chk("torch", led_mode_o, M_TORCH);
    chk("torch current", led_current_ma_o, 9'h078);
    wr(SUB_OMODE, '{8'h00});
    #1;
    chk("torch barred", led_mode_o, M_OFF);
    torch <= 1'b0;
    wr(SUB_ID, '{8'hff, 8'hff});
    wr(8'h07, '{8'h77});
    rd(SUB_ID, '{DID, 8'h01});
    rd(8'h07, '{8'h00});
    i_host.start();
    i_host.xfer(8'h62, 1'b1, q, a);
    chk("foreign address", a, 9'h001);
    i_host.stop();
    $display("register writes done");
  endtask
  task automatic t_undervoltage_lockout();
    wr(SUB_TMR, '{8'h03});
    low_supply <= 1'b1;
    i_host.tick(4);
    low_supply <= 1'b0;
    i_host.tick(4);
    rd(SUB_TMR, '{RST_TMR, RST_CUR, RST_OMODE});
    $display("undervoltage done");
  endtask
  // default setting 0xf gives a 200 cycle flash before the timeout
  task automatic t_timer();
    strobe <= 1'b1;
    i_host.tick(150);
    #1;
    chk("strobe flash", led_mode_o, M_FLASH);
    chk("strobe current", led_current_ma_o, 9'h140);
    i_host.tick(100);
    #1;
    chk("timeout off", led_mode_o, M_OFF);
    strobe <= 1'b0;
    rd(SUB_FAULT, '{8'h18});
    rd(SUB_FAULT, '{8'h08});
    $display("flash timeout done");
  endtask
  task automatic t_twobit();
    logic [8:0] lo;
    logic [8:0] hi;
    isel <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      two_led <= k[0];
      lo = k ? 9'h028 : 9'h050;
      hi = k ? 9'h140 : 9'h1f4;
      pins(4'b0000, M_OFF, 9'h000);
      chk("led count", ft_pin, {8'h00, k[0]});
      chk("strobe drive", ft_oe, 9'h001);
      pins(4'b0010, M_TORCH, lo);
      pins(4'b0100, M_ASSIST, lo);
      pins(4'b1100, M_FLASH, hi);
      pins(4'b1101, M_FLASH, lo);
      {sel_one, sel_two, torch, tx} <= 4'b1010;
      i_host.tick(6);
      #1;
      chk("reserved", led_current_ma_o, 9'h000);
    end
    $display("two-bit decode done");
  endtask
  task automatic t_ovp();
    pins(4'b1100, M_FLASH, 9'h140);
    ovp <= 1'b1;
    i_host.tick(6);
    #1;
    chk("overvoltage off", led_current_ma_o, 9'h000);
    ovp <= 1'b0;
    pins(4'b0100, M_OFF, 9'h000);
    pins(4'b0000, M_OFF, 9'h000);
    pins(4'b0100, M_ASSIST, 9'h028);
    // with the enable low the flash request must not reach the outputs
    ce <= 1'b0;
    pins(4'b1100, M_ASSIST, 9'h028);
    ce <= 1'b1;
    pins(4'b1100, M_FLASH, 9'h140);
    $display("overvoltage fault done");
  endtask
  initial begin
    i_host.tick(4);
    rst <= 1'b0;
    i_host.tick(5);
    t_regs();
    t_write();
    t_undervoltage_lockout();
    t_timer();
    t_twobit();
    t_ovp();
    report_and_stop();
  end
  // the whole sequence needs well under 10000 cycles
  initial begin
    #400_000;
    n_fail++;
    report_and_stop();
  end
endmodule
